// ===== include/dom_regs.vh
// register offsets, field positions, reset values and codes for the
// drive operation mode controller; included by the design, checker and bench files
`ifndef DOM_REGS_VH
`define DOM_REGS_VH

// word byte addresses on the wishbone slave
`define DOM_CTRL_ADDR      8'h00
`define DOM_PARAM_ADDR     8'h04
`define DOM_STATION_ADDR   8'h08
`define DOM_STATUS_ADDR    8'h0C
`define DOM_ID_ADDR        8'h10

// control register bits (write 1 pulses, except the two-bit target field)
`define DOM_CTRL_REQ_BIT   0
`define DOM_CTRL_TGT_LSB   1
`define DOM_CTRL_TGT_MSB   2
`define DOM_CTRL_CLRERR    3
`define DOM_CTRL_POWERON   4

// parameter register fields
`define DOM_MSEL_LSB       0
`define DOM_MSEL_MSB       3
`define DOM_LSTART_LSB     8
`define DOM_LSTART_MSB     9

// reset values
`define DOM_MSEL_RST       4'h0
`define DOM_LSTART_RST     2'h0

// control source codes
`define DOM_SRC_PANEL      2'h0
`define DOM_SRC_TERM       2'h1
`define DOM_SRC_LINK       2'h2

// display character codes, three ascii letters packed
`define DOM_DISP_PANEL     24'h205055
`define DOM_DISP_TERM      24'h455854
`define DOM_DISP_LINK      24'h4E4554

// station range and claim
`define DOM_STATION_MIN    6'h01
`define DOM_STATION_MAX    6'h3D
`define DOM_STATION_SPAN   6'h04

// arbitrary neutral identity value
`define DOM_ID_VALUE       32'h0000A5A5

`endif

// ===== src/dom_sync.v
// two flip-flop synchroniser for one asynchronous level
// assumes a single clock and synchronous active high reset
`timescale 1ns/1ps
module dom_sync (
    // clock and reset
    input  wire clk,
    input  wire rst,
    // level in and out
    input  wire d,
    output reg  q
);
    reg meta_q;

    // first stage read only by second stage
    always @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // dom_sync

// ===== src/dom_top.v
// operation mode controller for a drive with an optical link option
// assumes one 250 MHz clock, a classic wishbone master, async pins
//
// Notes on behaviour
// [RL1] station address valid only within 1 to 61 inclusive
// [RL2] unit claims four consecutive stations starting at its address
// [RL3] master changes address switches only while refresh is stopped
// [RL4] master sizes refresh from station total: plain plus four per drive
// [RL5] three sources; factory default is terminal control
// [RL6] master stops motor and both run commands before mode change
// [RL7] select 0: link allowed from terminal, refused from panel
// [RL8] select 1, 3 or 4: link control refused
// [RL9] select 5: link refused; terminal-writable parameters still writable
// [RL10] select 2 or 6: change to link control allowed; code allows select 2 only from terminal
// [RL11] select 7: link only from terminal with panel interlock asserted
// [RL12] select 8: link only from terminal with switch input asserted
// [RL13] terminal/link by master program; panel/terminal by panel keys
// [RL14] direct panel/link change only in switch-over mode
// [RL15] link start 1 or 2: enter link control at power-on and reset
// [RL16] link start 0: startup follows select, terminal 0/2, panel 1
// [RL17] link start honoured only when select is 0, 2 or 6
// [RL18] link start writes accepted in any control source
// [RL19] link start 2: brief power loss resumes previous run state
// [RL20] display shows panel, terminal or link code
// [RL21] in link control only master run commands act
// [RL22] link loss in link control trips alarm with slot error
// [RL23] refused mode change leaves source unchanged
`timescale 1ns/1ps
`include "dom_regs.vh"
module dom_top (
    // clock and reset
    input  wire        REF_CLK,
    input  wire        RST,
    // wishbone slave
    input  wire        CYC_I,
    input  wire        STB_I,
    input  wire        WE_I,
    input  wire [7:0]  ADR_I,
    input  wire [3:0]  SEL_I,
    input  wire [31:0] DAT_I,
    output reg  [31:0] DAT_O,
    output reg         ACK_O,
    // station switches and link status pins
    input  wire [5:0]  STATION_SW,
    input  wire        LINK_OK,
    input  wire        LINK_REFRESH,
    input  wire        OPTION_IN_SLOT3,
    // panel, terminal, link run and drive status pins
    input  wire        PANEL_KEY_TERM,
    input  wire        PANEL_KEY_PANEL,
    input  wire        PANEL_INTERLOCK_INPUT,
    input  wire        PANEL_TERMINAL_SWITCH_INPUT,
    input  wire        TERM_FWD,
    input  wire        TERM_REV,
    input  wire        PANEL_FWD,
    input  wire        PANEL_REV,
    input  wire        LINK_FWD,
    input  wire        LINK_REV,
    input  wire        MOTOR_STOPPED,
    input  wire        BRIEF_POWER_LOSS,
    // drive outputs
    output reg  [1:0]  SOURCE,
    output reg  [23:0] DISPLAY_CODE,
    output reg         RUN_FWD,
    output reg         RUN_REV,
    output reg         ALARM_STOP,
    output reg         SLOT_TWO_OPTION_ERROR,
    output reg         SLOT_THREE_OPTION_ERROR,
    output reg  [5:0]  STATION_FIRST,
    output reg  [5:0]  STATION_LAST,
    output reg         STATION_VALID
);
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers, one per asynchronous level
    localparam NSYNC = 18;
    wire [NSYNC-1:0] pin_raw;
    wire [NSYNC-1:0] pin_s;
    assign pin_raw = {STATION_SW, LINK_OK, LINK_REFRESH, PANEL_KEY_TERM,
                      PANEL_KEY_PANEL, PANEL_INTERLOCK_INPUT,
                      PANEL_TERMINAL_SWITCH_INPUT, TERM_FWD, TERM_REV,
                      PANEL_FWD, PANEL_REV, LINK_FWD, LINK_REV};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            dom_sync u_sync (
                .clk (REF_CLK),
                .rst (RST),
                .d   (pin_raw[gi]),
                .q   (pin_s[gi])
            );
        end
    endgenerate

    wire [5:0] sw_s       = pin_s[17:12];
    wire       link_ok_s  = pin_s[11];
    wire       refresh_s  = pin_s[10];
    wire       key_term_s = pin_s[9];
    wire       key_panel_s = pin_s[8];
    wire       interlock_s = pin_s[7];
    wire       pt_switch_s = pin_s[6];
    wire       t_fwd_s    = pin_s[5];
    wire       t_rev_s    = pin_s[4];
    wire       p_fwd_s    = pin_s[3];
    wire       p_rev_s    = pin_s[2];
    wire       l_fwd_s    = pin_s[1];
    wire       l_rev_s    = pin_s[0];

    // slower pins on their own synchronisers
    wire stopped_s;
    wire ploss_s;
    wire slot3_s;
    dom_sync u_sync_stop (
        .clk (REF_CLK),
        .rst (RST),
        .d   (MOTOR_STOPPED),
        .q   (stopped_s)
    );
    dom_sync u_sync_ploss (
        .clk (REF_CLK),
        .rst (RST),
        .d   (BRIEF_POWER_LOSS),
        .q   (ploss_s)
    );
    dom_sync u_sync_slot (
        .clk (REF_CLK),
        .rst (RST),
        .d   (OPTION_IN_SLOT3),
        .q   (slot3_s)
    );

    ////////////////////////////////////////////////////////////////////
    // functions

    // permission to enter link control from a given source
    function link_allowed;
        input [3:0] msel;
        input [1:0] src;
        input       ilock;
        input       psw;
        begin
            case (msel)
                4'h0: link_allowed = (src == `DOM_SRC_TERM); // RL7
                4'h2: link_allowed = (src == `DOM_SRC_TERM); // RL10
                4'h6: link_allowed = 1'b1;                   // RL10 RL14
                4'h7: link_allowed = (src == `DOM_SRC_TERM)
                                     && ilock;               // RL11
                4'h8: link_allowed = (src == `DOM_SRC_TERM)
                                     && psw;                 // RL12
                default: link_allowed = 1'b0;                // RL8 RL9
            endcase
        end
    endfunction

    // startup source from the two parameters
    function [1:0] start_src;
        input [3:0] msel;
        input [1:0] lstart;
        begin
            if ((msel == 4'h0 || msel == 4'h2 || msel == 4'h6)   // RL17
                && (lstart == 2'h1 || lstart == 2'h2))
                start_src = `DOM_SRC_LINK;                      // RL15
            else if (msel == 4'h1)
                start_src = `DOM_SRC_PANEL;                     // RL16
            else
                start_src = `DOM_SRC_TERM;                      // RL16
        end
    endfunction

    // display text for a source
    function [23:0] disp_of;
        input [1:0] src;
        begin
            case (src)
                `DOM_SRC_PANEL: disp_of = `DOM_DISP_PANEL;
                `DOM_SRC_LINK:  disp_of = `DOM_DISP_LINK;
                default:        disp_of = `DOM_DISP_TERM;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // wishbone decode and registers
    reg  [3:0] msel_q;
    reg  [1:0] lstart_q;
    reg  [1:0] src_q;
    reg        refused_q;
    reg        addr_err_q;
    wire       wb_req = CYC_I && STB_I && !ACK_O;
    wire       wb_wr  = wb_req && WE_I;
    wire       wr_ctrl  = wb_wr && (ADR_I == `DOM_CTRL_ADDR) && SEL_I[0];
    wire       wr_param = wb_wr && (ADR_I == `DOM_PARAM_ADDR);
    wire       req_mode = wr_ctrl && DAT_I[`DOM_CTRL_REQ_BIT];
    wire [1:0] req_tgt  = DAT_I[`DOM_CTRL_TGT_MSB:`DOM_CTRL_TGT_LSB];
    wire       clr_err  = wr_ctrl && DAT_I[`DOM_CTRL_CLRERR];
    wire       sw_reset = wr_ctrl && DAT_I[`DOM_CTRL_POWERON];

    // one wait-free answer: ack one cycle after request seen
    always @(posedge REF_CLK) begin
        if (RST)
            ACK_O <= 1'b0;
        else
            ACK_O <= wb_req;
    end

    // parameters; link start writable in any source, byte lane gated
    always @(posedge REF_CLK) begin
        if (RST) begin
            msel_q   <= `DOM_MSEL_RST;
            lstart_q <= `DOM_LSTART_RST;
        end else if (wr_param) begin
            if (SEL_I[0] && (src_q != `DOM_SRC_LINK))
                msel_q <= DAT_I[`DOM_MSEL_MSB:`DOM_MSEL_LSB];
            if (SEL_I[1])
                lstart_q <= DAT_I[`DOM_LSTART_MSB:`DOM_LSTART_LSB]; // RL18
        end
    end

    // read mux
    always @(posedge REF_CLK) begin
        if (RST) begin
            DAT_O <= 32'h00000000;
        end else if (wb_req && !WE_I) begin
            case (ADR_I)
                `DOM_PARAM_ADDR:   DAT_O <= {22'h0, lstart_q, 4'h0, msel_q};
                `DOM_STATION_ADDR: DAT_O <= {15'h0, STATION_VALID,
                                             2'h0, STATION_LAST,
                                             2'h0, STATION_FIRST};
                `DOM_STATUS_ADDR:  DAT_O <= {24'h0, addr_err_q,
                                             ALARM_STOP, refused_q,
                                             3'h0, src_q};
                `DOM_ID_ADDR:      DAT_O <= `DOM_ID_VALUE;
                default:           DAT_O <= 32'h00000000;
            endcase
        end else begin
            DAT_O <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // station address claim
    wire sw_in_range = (sw_s >= `DOM_STATION_MIN) &&
                       (sw_s <= `DOM_STATION_MAX);          // RL1

    // latch only while refresh is idle; switches held otherwise
    always @(posedge REF_CLK) begin
        if (RST) begin
            STATION_FIRST <= 6'h00;
            STATION_LAST  <= 6'h00;
            STATION_VALID <= 1'b0;
            addr_err_q    <= 1'b0;
        end else if (!refresh_s) begin                      // RL3
            STATION_VALID <= sw_in_range;
            addr_err_q    <= !sw_in_range;
            STATION_FIRST <= sw_s;
            STATION_LAST  <= sw_s + `DOM_STATION_SPAN - 6'h01; // RL2 RL4
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode state
    reg        link_seen_q;
    reg  [1:0] held_src_q;
    reg        start_q;
    wire       quiet = stopped_s && !t_fwd_s && !t_rev_s &&
                       !p_fwd_s && !p_rev_s;                // RL6
    reg  [1:0] src_d;
    reg        refused_d;

    // next source; refused requests leave src_q as is
    always @* begin
        src_d     = src_q;
        refused_d = refused_q && !clr_err;
        if (start_q) begin
            src_d = start_src(msel_q, lstart_q);
        end else if (req_mode) begin                        // RL13
            if (!quiet) begin
                refused_d = 1'b1;                           // RL23
            end else if (req_tgt == `DOM_SRC_LINK) begin
                if (link_allowed(msel_q, src_q, interlock_s, pt_switch_s))
                    src_d = `DOM_SRC_LINK;
                else
                    refused_d = 1'b1;                       // RL23
            end else if (req_tgt == `DOM_SRC_TERM &&
                         src_q == `DOM_SRC_LINK) begin
                src_d = `DOM_SRC_TERM;                      // RL13
            end else if (req_tgt == `DOM_SRC_PANEL &&
                         src_q == `DOM_SRC_LINK &&
                         msel_q == 4'h6) begin
                src_d = `DOM_SRC_PANEL;                     // RL14
            end else begin
                refused_d = 1'b1;                           // RL23
            end
        end else if (quiet && src_q != `DOM_SRC_LINK &&
                     (msel_q == 4'h0 || msel_q == 4'h6)) begin
            if (key_panel_s)
                src_d = `DOM_SRC_PANEL;                     // RL13
            else if (key_term_s)
                src_d = `DOM_SRC_TERM;                      // RL13
        end
    end

    // source register; startup pass after reset and on software reset
    always @(posedge REF_CLK) begin
        if (RST) begin
            src_q     <= `DOM_SRC_TERM;                     // RL5
            refused_q <= 1'b0;
            start_q   <= 1'b1;
        end else begin
            src_q     <= src_d;
            refused_q <= refused_d || (req_mode && clr_err && src_d == src_q
                                       && req_tgt != src_q);
            start_q   <= sw_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // run command steering and brief power loss hold
    always @(posedge REF_CLK) begin
        if (RST) begin
            RUN_FWD    <= 1'b0;
            RUN_REV    <= 1'b0;
            held_src_q <= `DOM_SRC_TERM;
        end else if (ploss_s && lstart_q == 2'h2) begin
            RUN_FWD <= RUN_FWD;                             // RL19
            RUN_REV <= RUN_REV;                             // RL19
        end else if (ploss_s || ALARM_STOP) begin
            RUN_FWD <= 1'b0;
            RUN_REV <= 1'b0;
        end else begin
            held_src_q <= src_q;
            case (src_q)
                `DOM_SRC_LINK: begin
                    RUN_FWD <= l_fwd_s;                     // RL21
                    RUN_REV <= l_rev_s;                     // RL21
                end
                `DOM_SRC_PANEL: begin
                    RUN_FWD <= p_fwd_s;
                    RUN_REV <= p_rev_s;
                end
                default: begin
                    RUN_FWD <= t_fwd_s;
                    RUN_REV <= t_rev_s;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link loss trip; sticky until software clears with link back
    always @(posedge REF_CLK) begin
        if (RST) begin
            ALARM_STOP              <= 1'b0;
            SLOT_TWO_OPTION_ERROR   <= 1'b0;
            SLOT_THREE_OPTION_ERROR <= 1'b0;
        end else if (src_q == `DOM_SRC_LINK && !link_ok_s) begin
            ALARM_STOP              <= 1'b1;                // RL22
            SLOT_TWO_OPTION_ERROR   <= !slot3_s;            // RL22
            SLOT_THREE_OPTION_ERROR <= slot3_s;             // RL22
        end else if (clr_err) begin
            ALARM_STOP              <= 1'b0;
            SLOT_TWO_OPTION_ERROR   <= 1'b0;
            SLOT_THREE_OPTION_ERROR <= 1'b0;
        end
    end

    // source and display outputs
    always @(posedge REF_CLK) begin
        if (RST) begin
            SOURCE       <= `DOM_SRC_TERM;
            DISPLAY_CODE <= `DOM_DISP_TERM;
        end else begin
            SOURCE       <= src_q;
            DISPLAY_CODE <= disp_of(src_q);                 // RL20
        end
    end

    // held_src_q follows src_q outside loss and alarm; no logic reads it
    wire unused_hold = ^held_src_q;
endmodule // dom_top

// ===== tb/dom_link_master.sv
// behavioural link master standing across the optical link
// assumes the bench steers it by levels changed at the clock edge
`timescale 1ns/1ps
module dom_link_master #(
    parameter int PLAIN  = 1,
    parameter int DRIVES = 1
) (
    // clock and reset
    input  wire  clk,
    input  wire  rst,
    // bench controls
    input  wire  en,
    input  wire  cut,
    input  wire  fwd,
    // link pins
    output logic link_ok,
    output logic refresh,
    output logic run_fwd,
    output logic run_rev
);
    // refresh range: plain stations plus four per drive
    localparam int TOTAL = PLAIN + 4 * DRIVES;
    logic tog_q;
    ////////////////////////////////////////////////////////////////////////
    // a dead link shows a toggling pattern on the run pins; link_ok and refresh are held low
    always @(posedge clk) begin
        tog_q   <= rst ? 1'b0 : ~tog_q;
        link_ok <= !rst && en && !cut;
        refresh <= !rst && en && !cut && TOTAL > 0;
        run_fwd <= (en && !cut) ? fwd : tog_q;
        run_rev <= (en && !cut) ? 1'b0 : ~tog_q;
    end
endmodule // dom_link_master

// ===== tb/dom_top_sva.sv
// port checker for the mode controller, bound onto the top module
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
`include "dom_regs.vh"
module dom_sva (
    // clock and reset
    input wire        REF_CLK,
    input wire        RST,
    // bus handshake
    input wire        CYC_I,
    input wire        STB_I,
    input wire        ACK_O,
    // mode, link and station
    input wire        LINK_OK,
    input wire [1:0]  SOURCE,
    input wire [23:0] DISPLAY_CODE,
    input wire        RUN_FWD,
    input wire        RUN_REV,
    input wire        ALARM_STOP,
    input wire        SLOT_TWO_OPTION_ERROR,
    input wire        SLOT_THREE_OPTION_ERROR,
    input wire [5:0]  STATION_FIRST,
    input wire [5:0]  STATION_LAST,
    input wire        STATION_VALID
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////
    // display and source are both registered from src_q on the same edge; the stable pair skips the change cycle
    property p_disp_link;
        SOURCE == `DOM_SRC_LINK && $past(SOURCE) == `DOM_SRC_LINK
            |-> DISPLAY_CODE == `DOM_DISP_LINK;
    endproperty
    property p_disp_term;
        SOURCE == `DOM_SRC_TERM && $past(SOURCE) == `DOM_SRC_TERM
            |-> DISPLAY_CODE == `DOM_DISP_TERM;
    endproperty
    // reset itself is the cause here, so no disable
    property p_src_reset;
        disable iff (1'b0) RST |=> SOURCE == `DOM_SRC_TERM && !ALARM_STOP;
    endproperty
    property p_ack;
        CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O;
    endproperty
    property p_stn_range;
        STATION_VALID |-> STATION_FIRST >= `DOM_STATION_MIN
            && STATION_FIRST <= `DOM_STATION_MAX;
    endproperty
    property p_stn_span;
        STATION_VALID |-> STATION_LAST == STATION_FIRST + 6'h03;
    endproperty
    property p_alarm;
        (SOURCE == `DOM_SRC_LINK && !LINK_OK) [*2] |-> ##[0:4] ALARM_STOP;
    endproperty
    property p_alarm_code;
        ALARM_STOP |-> SLOT_TWO_OPTION_ERROR || SLOT_THREE_OPTION_ERROR;
    endproperty
    property p_alarm_run;
        ALARM_STOP && $past(ALARM_STOP) |-> !RUN_FWD && !RUN_REV;
    endproperty
    ////////////////////////////////////////////////////////////////////////
    a_disp_link: assert property (p_disp_link)
        else $error("display code wrong for link control");
    a_disp_term: assert property (p_disp_term)
        else $error("display code wrong for terminal control");
    a_src_reset: assert property (p_src_reset)
        else $error("reset did not select terminal control");
    a_ack: assert property (p_ack)
        else $error("bus ack not a single cycle after request");
    a_stn_range: assert property (p_stn_range)
        else $error("station flagged valid out of range");
    a_stn_span: assert property (p_stn_span)
        else $error("claimed station span is not four");
    a_alarm: assert property (p_alarm)
        else $error("link loss did not trip the alarm");
    a_alarm_code: assert property (p_alarm_code)
        else $error("alarm without slot error code");
    a_alarm_run: assert property (p_alarm_run)
        else $error("run output active during alarm");
    c_link: cover property (SOURCE == `DOM_SRC_LINK);
    c_alarm: cover property (ALARM_STOP);
    c_top: cover property (STATION_VALID && STATION_FIRST == 6'h3D);
endmodule // dom_sva

bind dom_top dom_sva u_sva (.REF_CLK, .RST, .CYC_I, .STB_I, .ACK_O,
    .LINK_OK, .SOURCE, .DISPLAY_CODE, .RUN_FWD, .RUN_REV, .ALARM_STOP,
    .SLOT_TWO_OPTION_ERROR, .SLOT_THREE_OPTION_ERROR, .STATION_FIRST,
    .STATION_LAST, .STATION_VALID);

// ===== tb/dom_top_tb.sv
// self-checking bench for the drive operation mode controller
// assumes the link master model and the bound port checker
`timescale 1ns/1ps
`include "dom_regs.vh"
module dom_top_tb;
    logic        clk = 1'b0, rst, cyc, stb, we, ack;
    logic [7:0]  adr;
    logic [3:0]  sel, m;
    logic [31:0] dat_i, dat_o, exp_q[$], msk_q[$];
    logic [23:0] disp;
    logic [5:0]  sw, st;
    logic [5:0]  pick [5] = '{6'h01, 6'h01, 6'h3D, 6'h00, 6'h3E};
    logic [1:0]  src;
    logic        lok, lref, slot3, kext, kpu, ilock, psw, tfwd, trev;
    logic        pfwd, prev, lfwd, lfwd_o, lrev, mstop, bpl, en, cut;
    logic        rfwd, rrev, alarm, e2, e3, ok, v;
    int          num_errors = 0, checks_done = 0, i, seed;

    dom_top dut (
        .REF_CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o),
        .ACK_O(ack), .STATION_SW(sw), .LINK_OK(lok), .LINK_REFRESH(lref),
        .OPTION_IN_SLOT3(slot3), .PANEL_KEY_TERM(kext), .PANEL_KEY_PANEL(kpu),
        .PANEL_INTERLOCK_INPUT(ilock), .PANEL_TERMINAL_SWITCH_INPUT(psw),
        .TERM_FWD(tfwd), .TERM_REV(trev), .PANEL_FWD(pfwd),
        .PANEL_REV(prev), .LINK_FWD(lfwd_o), .LINK_REV(lrev),
        .MOTOR_STOPPED(mstop), .BRIEF_POWER_LOSS(bpl), .SOURCE(),
        .DISPLAY_CODE(disp), .RUN_FWD(rfwd), .RUN_REV(rrev),
        .ALARM_STOP(alarm), .SLOT_TWO_OPTION_ERROR(e2),
        .SLOT_THREE_OPTION_ERROR(e3), .STATION_FIRST(),
        .STATION_LAST(), .STATION_VALID());
    dom_link_master lm (.clk(clk), .rst(rst), .en(en), .cut(cut),
        .fwd(lfwd), .link_ok(lok), .refresh(lref), .run_fwd(lfwd_o),
        .run_rev(lrev));

    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            num_errors++;
            $display("mismatch at %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one classic cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            num_errors++;
            give_verdict();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, mk);
        exp_q.push_back(e);
        msk_q.push_back(mk);
        wb(1'b0, a, 32'h0);
    endtask
    task automatic reset_dut();
        rst <= 1'b1;
        idle(4);
        rst <= 1'b0;
    endtask
    // read data is judged at the ack edge against the oldest note
    always @(posedge clk)
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
            chk(dat_o & msk_q.pop_front(), exp_q.pop_front());
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hA161;
        {cyc, stb, we, kpu, kext, tfwd, trev, pfwd, prev} = '0;
        {slot3, bpl, en, cut, lfwd, adr, sel, dat_i} = '0;
        {ilock, psw, mstop, rst, sw} = {4'hF, 6'h05};
        idle(4);
        rst <= 1'b0;
        rd(`DOM_STATUS_ADDR, 32'h01, 32'h63);
        rd(`DOM_PARAM_ADDR, 32'h0, 32'h30F);
        rd(`DOM_ID_ADDR, `DOM_ID_VALUE, 32'hFFFFFFFF);
        rd(8'h14, 32'h0, 32'hFFFFFFFF);
        $display("test reset done");
        // switches move only while refresh is stopped
        for (i = 0; i < 5; i++) begin
            st = (i == 1) ? 6'({$random(seed)} % 58 + 1) : pick[i];
            sw <= st;
            idle(6);
            v = st >= 6'h01 && st <= 6'h3D;
            if (v && st < 6'h3B)
                rd(`DOM_STATION_ADDR, {15'h0, 1'b1, 2'b00, st + 6'h03,
                   2'b00, st}, 32'h1FFFF);
            else
                rd(`DOM_STATION_ADDR, {15'h0, v, 16'h0}, 32'h10000);
        end
        $display("test station done");
        en <= 1'b1;
        for (i = 0; i < 12; i++) begin
            m = i < 9 ? i[3:0] : (i == 9 ? 4'h7 : (i == 10 ? 4'h2 : 4'h8));
            ilock <= i != 9;
            mstop <= i != 10;
            psw <= i != 11;
            wb(1'b1, `DOM_PARAM_ADDR, {28'h0, m});
            wb(1'b1, `DOM_CTRL_ADDR, 32'h08);
            idle(4);
            wb(1'b1, `DOM_CTRL_ADDR, 32'h05);
            idle(4);
            ok = i < 9 && m inside {4'h0, 4'h2, 4'h6, 4'h7, 4'h8};
            src = ok ? 2'h2 : 2'h1;
            rd(`DOM_STATUS_ADDR, {26'h0, !ok, 3'b000, src},
               32'h23);
            wb(1'b1, `DOM_CTRL_ADDR, 32'h03);
        end
        $display("test mode table done");
        {ilock, psw, mstop} <= 3'h7;
        reset_dut();
        kpu <= 1'b1;
        idle(6);
        kpu <= 1'b0;
        idle(4);
        chk(disp, `DOM_DISP_PANEL);
        wb(1'b1, `DOM_CTRL_ADDR, 32'h05);
        idle(4);
        rd(`DOM_STATUS_ADDR, 32'h20, 32'h23);
        kext <= 1'b1;
        idle(6);
        kext <= 1'b0;
        idle(4);
        rd(`DOM_STATUS_ADDR, 32'h21, 32'h23);
        $display("test panel keys done");
        wb(1'b1, `DOM_PARAM_ADDR, 32'h100);
        wb(1'b1, `DOM_CTRL_ADDR, 32'h10);
        idle(4);
        rd(`DOM_STATUS_ADDR, 32'h02, 32'h03);
        lfwd <= 1'b1;
        trev <= 1'b1;
        idle(6);
        chk(disp, `DOM_DISP_LINK);
        chk({rfwd, rrev}, 2'b10);
        wb(1'b1, `DOM_PARAM_ADDR, 32'h205);
        rd(`DOM_PARAM_ADDR, 32'h200, 32'h30F);
        lfwd <= 1'b0;
        trev <= 1'b0;
        idle(4);
        wb(1'b1, `DOM_CTRL_ADDR, 32'h03);
        idle(4);
        rd(`DOM_STATUS_ADDR, 32'h01, 32'h03);
        wb(1'b1, `DOM_PARAM_ADDR, 32'h101);
        wb(1'b1, `DOM_CTRL_ADDR, 32'h10);
        idle(4);
        rd(`DOM_STATUS_ADDR, 32'h00, 32'h03);
        $display("test startup done");
        wb(1'b1, `DOM_PARAM_ADDR, 32'h206);
        wb(1'b1, `DOM_CTRL_ADDR, 32'h10);
        slot3 <= 1'b1;
        lfwd <= 1'b1;
        idle(6);
        cut <= 1'b1;
        idle(8);
        chk({alarm, e2, e3, rfwd}, 4'hA);
        rd(`DOM_STATUS_ADDR, 32'h40, 32'h40);
        cut <= 1'b0;
        lfwd <= 1'b0;
        idle(4);
        wb(1'b1, `DOM_CTRL_ADDR, 32'h08);
        idle(4);
        rd(`DOM_STATUS_ADDR, 32'h00, 32'h40);
        lfwd <= 1'b1;
        idle(6);
        bpl <= 1'b1;
        idle(3);
        lfwd <= 1'b0;
        idle(6);
        chk(rfwd, 1'b1);
        wb(1'b1, `DOM_CTRL_ADDR, 32'h01);
        idle(4);
        rd(`DOM_STATUS_ADDR, 32'h00, 32'h03);
        $display("test link loss done");
        idle(4);
        give_verdict();
    end
endmodule // dom_top_tb
